// ==== verilog/nv_ctrl_pkg.sv ====
// constants and types for the serial memory command controller
// How it works
// - type strap picks link, size strap picks range
// - pin drive depends on selected link kind
// - loader owns controller; host commands held off
// - three-wire link runs all eight commands
// - two-wire link runs read, write, reload only
// - loader fetches memory with read command only
// - busy bit starts command; cleared when done
// - read byte lands in data register
// - erase every, protect, reload need only code
// - no answer in 30 ms sets flag
// - loader copies settings out after reset
// - missing acknowledge aborts and sets flag
package nv_ctrl_pkg;
   // clock and link timing
   localparam int CLK_NS = 50;
   localparam int CLK_HZ = 20_000_000;
   localparam int NO_RESP_MS = 30;
   localparam int NO_RESP_CYC = NO_RESP_MS * (CLK_HZ / 1000);
   localparam int LINK_HZ = 100_000;
   localparam int QUARTER_NS = 1_000_000_000 / (LINK_HZ * 4);
   localparam int QUARTER_CYC = (QUARTER_NS / CLK_NS < 1) ? 1 : QUARTER_NS / CLK_NS;
   localparam int STRAP_WAIT = 2;
   // command codes
   localparam logic [2:0] CMD_READ = 3'h0;
   localparam logic [2:0] CMD_PROTECT_ON = 3'h1;
   localparam logic [2:0] CMD_PROTECT_OFF = 3'h2;
   localparam logic [2:0] CMD_WRITE = 3'h3;
   localparam logic [2:0] CMD_WRITE_EVERY = 3'h4;
   localparam logic [2:0] CMD_ERASE_EVERY = 3'h5;
   localparam logic [2:0] CMD_ERASE = 3'h6;
   localparam logic [2:0] CMD_RELOAD = 3'h7;
   // two-wire framing
   localparam logic [3:0] I2C_CTRL_CODE = 4'ha;
   localparam logic [2:0] STEP_CTRL_W = 3'h1;
   localparam logic [2:0] STEP_ADDR_H = 3'h2;
   localparam logic [2:0] STEP_ADDR_L = 3'h3;
   localparam logic [2:0] STEP_DATA = 3'h4;
   localparam logic [2:0] STEP_CTRL_R = 3'h5;
   localparam logic [2:0] STEP_RX = 3'h6;
   localparam logic [2:0] STEP_RD_STOP = 3'h7;
   localparam logic [2:0] STEP_WR_STOP = 3'h5;
   localparam logic [4:0] I2C_LAST_BIT = 5'h08;
   // three-wire opcodes
   localparam logic [1:0] MW_OP_READ = 2'h2;
   localparam logic [1:0] MW_OP_WRITE = 2'h1;
   localparam logic [1:0] MW_OP_ERASE = 2'h3;
   localparam logic [1:0] MW_OP_EXT = 2'h0;
   localparam logic [1:0] MW_EXT_OFF = 2'h3;
   localparam logic [1:0] MW_EXT_ON = 2'h0;
   localparam logic [1:0] MW_EXT_ERASE = 2'h2;
   localparam logic [1:0] MW_EXT_WRITE = 2'h1;
   localparam int MW_ADDR_BASE = 7;
   // reset values
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [15:0] LOAD_FIRST = 16'h0000;
   typedef enum logic [2:0] {ST_IDLE, ST_I2C, ST_MW_SHIFT, ST_MW_GAP, ST_MW_WAIT} state_t;
   typedef enum logic [1:0] {K_START, K_TX, K_RX, K_STOP} item_t;
endpackage : nv_ctrl_pkg

// ==== verilog/pin_sync.sv ====
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   genvar i;
   // one meta and one stable flop per bit
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         logic stab_r;
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               meta_r <= 1'b0;
               stab_r <= 1'b0;
            end else if (ce) begin
               meta_r <= d[i];
               stab_r <= meta_r;
            end
         end
         assign q[i] = stab_r;
      end
   endgenerate
endmodule : pin_sync

// ==== verilog/nv_eeprom_ctrl.sv ====
// command controller and reset loader for an external serial memory
`timescale 1ns/1ps
module nv_eeprom_ctrl #(
   parameter int TIMEOUT_CYC = nv_ctrl_pkg::NO_RESP_CYC,
   parameter int LOAD_LEN = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic link_type_strap,
   input wire logic [1:0] size_range_strap,
   input wire logic cmd_write,
   input wire logic [2:0] cmd_code,
   input wire logic [15:0] cmd_location,
   input wire logic cmd_start,
   input wire logic cmd_flag_clear,
   input wire logic data_write,
   input wire logic [7:0] data_wdata,
   output logic op_in_progress_bit,
   output logic no_response_flag,
   output logic [7:0] nv_data_reg,
   output logic loader_active,
   output logic load_valid,
   output logic [15:0] load_index,
   output logic [7:0] load_byte,
   input wire logic twowire_data_pin_in,
   output logic twowire_data_pin_out,
   output logic twowire_data_pin_oe,
   output logic threewire_in_pulldown,
   input wire logic twowire_clock_pin_in,
   output logic twowire_clock_pin_out,
   output logic twowire_clock_pin_oe,
   output logic threewire_select_pin_out,
   output logic threewire_select_pin_oe,
   output logic threewire_out_pin_out,
   output logic threewire_out_pin_oe
);
   localparam int QW = $clog2(nv_ctrl_pkg::QUARTER_CYC + 1);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [QW-1:0] Q_LAST = QW'(nv_ctrl_pkg::QUARTER_CYC - 1);
   localparam logic [TW-1:0] T_LAST = TW'(TIMEOUT_CYC - 1);
   localparam logic [15:0] L_LAST = 16'(LOAD_LEN - 1);

   // step kind within a two-wire frame
   function automatic nv_ctrl_pkg::item_t i2c_kind(input logic [2:0] s, input logic rd);
      i2c_kind = nv_ctrl_pkg::K_TX;
      if (s == 3'h0 || (rd && s == nv_ctrl_pkg::STEP_DATA)) i2c_kind = nv_ctrl_pkg::K_START;
      else if (rd && s == nv_ctrl_pkg::STEP_RX) i2c_kind = nv_ctrl_pkg::K_RX;
      else if (s == (rd ? nv_ctrl_pkg::STEP_RD_STOP : nv_ctrl_pkg::STEP_WR_STOP)) i2c_kind = nv_ctrl_pkg::K_STOP;
   endfunction : i2c_kind

   // byte sent in a two-wire step; released lines where nothing is sent
   function automatic logic [7:0] i2c_byte(input logic [2:0] s, input logic rd, input logic [15:0] a,
                                           input logic [7:0] d, input logic two);
      logic [2:0] blk;
      blk = two ? 3'h0 : a[10:8];
      i2c_byte = 8'hff;
      if (s == nv_ctrl_pkg::STEP_CTRL_W) i2c_byte = {nv_ctrl_pkg::I2C_CTRL_CODE, blk, 1'b0};
      else if (s == nv_ctrl_pkg::STEP_ADDR_H) i2c_byte = a[15:8];
      else if (s == nv_ctrl_pkg::STEP_ADDR_L) i2c_byte = a[7:0];
      else if (s == nv_ctrl_pkg::STEP_DATA && !rd) i2c_byte = d;
      else if (s == nv_ctrl_pkg::STEP_CTRL_R && rd) i2c_byte = {nv_ctrl_pkg::I2C_CTRL_CODE, blk, 1'b1};
   endfunction : i2c_byte

   // bits sent on the three-wire link before any read-back
   function automatic int mw_bits(input logic [2:0] c, input logic [1:0] sz);
      mw_bits = 3 + nv_ctrl_pkg::MW_ADDR_BASE + int'(sz);
      if (c == nv_ctrl_pkg::CMD_WRITE || c == nv_ctrl_pkg::CMD_WRITE_EVERY) mw_bits = mw_bits + 8;
   endfunction : mw_bits

   // three-wire frame, left aligned: start bit, opcode, address, data
   function automatic logic [31:0] mw_vec(input logic [2:0] c, input logic [15:0] a, input logic [7:0] d,
                                          input logic [1:0] sz);
      logic [1:0] op;
      logic [15:0] ad;
      logic [31:0] v;
      logic wd;
      int aw;
      aw = nv_ctrl_pkg::MW_ADDR_BASE + int'(sz);
      op = nv_ctrl_pkg::MW_OP_EXT;
      ad = a;
      wd = 1'b0;
      unique case (c)
         nv_ctrl_pkg::CMD_READ: op = nv_ctrl_pkg::MW_OP_READ;
         nv_ctrl_pkg::CMD_WRITE: begin
            op = nv_ctrl_pkg::MW_OP_WRITE;
            wd = 1'b1;
         end
         nv_ctrl_pkg::CMD_ERASE: op = nv_ctrl_pkg::MW_OP_ERASE;
         nv_ctrl_pkg::CMD_PROTECT_OFF: ad = 16'(nv_ctrl_pkg::MW_EXT_OFF) << (aw - 2);
         nv_ctrl_pkg::CMD_PROTECT_ON: ad = 16'(nv_ctrl_pkg::MW_EXT_ON) << (aw - 2);
         nv_ctrl_pkg::CMD_ERASE_EVERY: ad = 16'(nv_ctrl_pkg::MW_EXT_ERASE) << (aw - 2);
         nv_ctrl_pkg::CMD_WRITE_EVERY: begin
            ad = 16'(nv_ctrl_pkg::MW_EXT_WRITE) << (aw - 2);
            wd = 1'b1;
         end
         nv_ctrl_pkg::CMD_RELOAD: ad = 16'h0000;
      endcase
      ad = ad & ((16'h0001 << aw) - 16'h0001);
      v = 32'h0000_0001;
      v = (v << 2) | 32'(op);
      v = (v << aw) | 32'(ad);
      if (wd) v = (v << 8) | 32'(d);
      mw_vec = v << (32 - mw_bits(c, sz));
   endfunction : mw_vec

   // reset release through two flops
   logic rst_meta_r;
   logic rstn_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rstn_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rstn_r <= rst_meta_r;
      end
   end

   // pins and straps into the clock domain
   logic [4:0] pin_s;
   pin_sync #(.W(5)) u_sync (
      .clk(clk),
      .rstn(rstn_r),
      .ce(ce),
      .d({size_range_strap, link_type_strap, twowire_clock_pin_in, twowire_data_pin_in}),
      .q(pin_s)
   );
   logic data_s;
   logic clk_s;
   assign data_s = pin_s[0];
   assign clk_s = pin_s[1];

   nv_ctrl_pkg::state_t state_r, state_nxt;
   logic [1:0] boot_r, boot_nxt, q_r, q_nxt, size_r, size_nxt;
   logic [QW-1:0] div_r, div_nxt;
   logic [TW-1:0] to_r, to_nxt;
   logic [2:0] step_r, step_nxt, cur_cmd_r, cur_cmd_nxt, op_cmd_r, op_cmd_nxt;
   logic [4:0] bit_r, bit_nxt, len_r, len_nxt;
   logic [31:0] sh_r, sh_nxt;
   logic [8:0] rx_r, rx_nxt;
   logic [15:0] cur_loc_r, cur_loc_nxt, op_loc_r, op_loc_nxt, idx_r, idx_nxt, lidx_r, lidx_nxt;
   logic [7:0] data_r, data_nxt, lbyte_r, lbyte_nxt;
   logic type_r, type_nxt, boot_done_r, boot_done_nxt, busy_r, busy_nxt, flag_r, flag_nxt;
   logic ldr_r, ldr_nxt, from_ldr_r, from_ldr_nxt, reload_r, reload_nxt, lvalid_r, lvalid_nxt;
   logic mw_wait_r, mw_wait_nxt, scl_rel_r, scl_rel_nxt, sda_rel_r, sda_rel_nxt;
   logic cs_r, cs_nxt, sck_r, sck_nxt, dout_r, dout_nxt;
   logic [7:0] pins_r, pins_nxt;
   logic tick, stall, finish, abort, rd, go;
   logic [2:0] gcmd, nstep;
   logic [15:0] gloc;
   logic [7:0] rbyte;
   nv_ctrl_pkg::item_t kind;

   // next state of the whole controller
   always_comb begin
      {state_nxt, boot_nxt, q_nxt, size_nxt, div_nxt, to_nxt, step_nxt} = {state_r, boot_r, q_r, size_r, div_r, to_r, step_r};
      {cur_cmd_nxt, op_cmd_nxt, bit_nxt, len_nxt, sh_nxt, rx_nxt} = {cur_cmd_r, op_cmd_r, bit_r, len_r, sh_r, rx_r};
      {cur_loc_nxt, op_loc_nxt, idx_nxt, lidx_nxt, data_nxt, lbyte_nxt} = {cur_loc_r, op_loc_r, idx_r, lidx_r, data_r, lbyte_r};
      {type_nxt, boot_done_nxt, busy_nxt, flag_nxt, ldr_nxt, from_ldr_nxt} = {type_r, boot_done_r, busy_r, flag_r, ldr_r, from_ldr_r};
      {reload_nxt, mw_wait_nxt, scl_rel_nxt, sda_rel_nxt, cs_nxt, sck_nxt, dout_nxt} = {reload_r, mw_wait_r, scl_rel_r, sda_rel_r, cs_r, sck_r, dout_r};
      lvalid_nxt = 1'b0;
      finish = 1'b0;
      abort = 1'b0;
      go = 1'b0;
      gcmd = cur_cmd_r;
      gloc = cur_loc_r;
      rd = (op_cmd_r == nv_ctrl_pkg::CMD_READ);
      kind = i2c_kind(step_r, rd);
      nstep = (step_r == nv_ctrl_pkg::STEP_CTRL_W && !size_r[0]) ? nv_ctrl_pkg::STEP_ADDR_L : step_r + 3'h1;
      rbyte = type_r ? rx_r[8:1] : rx_r[7:0];
      tick = (div_r == Q_LAST);
      stall = (state_r == nv_ctrl_pkg::ST_I2C && q_r == 2'h2 && !clk_s) || (state_r == nv_ctrl_pkg::ST_MW_WAIT && !data_s);
      // straps are caught once the synchronisers hold pin values
      if (!boot_done_r) begin
         boot_nxt = boot_r + 2'h1;
         if (boot_r == 2'(nv_ctrl_pkg::STRAP_WAIT)) begin
            type_nxt = pin_s[2];
            size_nxt = pin_s[4:3];
            boot_done_nxt = 1'b1;
            ldr_nxt = 1'b1;
            idx_nxt = nv_ctrl_pkg::LOAD_FIRST;
         end
      end
      // host register writes, held off while busy or loading, apart from the flag clear
      if (boot_done_r && !busy_r && !ldr_r) begin
         if (data_write) data_nxt = data_wdata;
         if (cmd_write) begin
            cur_cmd_nxt = cmd_code;
            cur_loc_nxt = cmd_location;
            busy_nxt = cmd_start;
         end
      end
      if (cmd_write && cmd_flag_clear) flag_nxt = 1'b0;
      // quarter-bit divider shared by both links
      if (state_r != nv_ctrl_pkg::ST_IDLE) begin
         div_nxt = tick ? (stall ? div_r : '0) : div_r + QW'(1);
         to_nxt = (tick && stall) ? to_r + TW'(1) : '0;
         if (tick && stall && to_r == T_LAST) abort = 1'b1;
         if (tick && !stall) q_nxt = q_r + 2'h1;
      end
      unique case (state_r)
         nv_ctrl_pkg::ST_IDLE: begin
            div_nxt = '0;
            q_nxt = 2'h0;
            bit_nxt = 5'h00;
            if (ldr_r) begin
               go = 1'b1;
               gcmd = nv_ctrl_pkg::CMD_READ;
               gloc = idx_r;
            end else if (busy_r) begin
               go = 1'b1;
            end
            if (go) begin
               from_ldr_nxt = ldr_r;
               op_cmd_nxt = gcmd;
               op_loc_nxt = gloc;
               if (gcmd == nv_ctrl_pkg::CMD_RELOAD) begin
                  ldr_nxt = 1'b1;
                  reload_nxt = 1'b1;
                  idx_nxt = nv_ctrl_pkg::LOAD_FIRST;
               end else if (type_r) begin
                  if (gcmd == nv_ctrl_pkg::CMD_READ || gcmd == nv_ctrl_pkg::CMD_WRITE) begin
                     state_nxt = nv_ctrl_pkg::ST_I2C;
                     step_nxt = 3'h0;
                  end else begin
                     busy_nxt = 1'b0;
                  end
               end else begin
                  state_nxt = nv_ctrl_pkg::ST_MW_SHIFT;
                  sh_nxt = mw_vec(gcmd, gloc, data_r, size_r);
                  len_nxt = 5'(mw_bits(gcmd, size_r) + ((gcmd == nv_ctrl_pkg::CMD_READ) ? 8 : 0));
                  mw_wait_nxt = (gcmd == nv_ctrl_pkg::CMD_WRITE || gcmd == nv_ctrl_pkg::CMD_WRITE_EVERY ||
                                 gcmd == nv_ctrl_pkg::CMD_ERASE || gcmd == nv_ctrl_pkg::CMD_ERASE_EVERY);
                  cs_nxt = 1'b1;
               end
            end
         end
         nv_ctrl_pkg::ST_I2C: begin
            if (tick && !stall) begin
               unique case (q_r)
                  2'h0: sda_rel_nxt = (kind == nv_ctrl_pkg::K_START) ? 1'b1 :
                                      (kind == nv_ctrl_pkg::K_STOP) ? 1'b0 : sh_r[8];
                  2'h1: scl_rel_nxt = 1'b1;
                  2'h2: begin
                     if (kind == nv_ctrl_pkg::K_START) sda_rel_nxt = 1'b0;
                     else if (kind == nv_ctrl_pkg::K_STOP) sda_rel_nxt = 1'b1;
                     else begin
                        rx_nxt = {rx_r[7:0], data_s};
                        sh_nxt = {sh_r[30:0], 1'b1};
                     end
                  end
                  2'h3: begin
                     if (kind == nv_ctrl_pkg::K_STOP) finish = 1'b1;
                     else begin
                        scl_rel_nxt = 1'b0;
                        bit_nxt = bit_r + 5'h01;
                        if (kind == nv_ctrl_pkg::K_START || bit_r == nv_ctrl_pkg::I2C_LAST_BIT) begin
                           bit_nxt = 5'h00;
                           step_nxt = nstep;
                           sh_nxt = {23'h0, i2c_byte(nstep, rd, op_loc_r, data_r, size_r[0]), 1'b1};
                           if (kind == nv_ctrl_pkg::K_TX && rx_r[0]) abort = 1'b1;
                        end
                     end
                  end
               endcase
            end
         end
         nv_ctrl_pkg::ST_MW_SHIFT: begin
            if (tick) begin
               unique case (q_r)
                  2'h0: dout_nxt = sh_r[31];
                  2'h1: sck_nxt = 1'b1;
                  2'h2: begin
                     rx_nxt = {rx_r[7:0], data_s};
                     sh_nxt = {sh_r[30:0], 1'b0};
                  end
                  2'h3: begin
                     sck_nxt = 1'b0;
                     bit_nxt = bit_r + 5'h01;
                     if (bit_r == len_r - 5'h01) begin
                        dout_nxt = 1'b0;
                        cs_nxt = 1'b0;
                        if (mw_wait_r) state_nxt = nv_ctrl_pkg::ST_MW_GAP;
                        else finish = 1'b1;
                     end
                  end
               endcase
            end
         end
         nv_ctrl_pkg::ST_MW_GAP: begin
            // select low for one bit time, then raise it to watch ready
            if (tick && q_r == 2'h3) begin
               cs_nxt = 1'b1;
               state_nxt = nv_ctrl_pkg::ST_MW_WAIT;
            end
         end
         nv_ctrl_pkg::ST_MW_WAIT: begin
            if (tick && !stall) begin
               cs_nxt = 1'b0;
               finish = 1'b1;
            end
         end
         default: state_nxt = nv_ctrl_pkg::ST_IDLE;
      endcase
      // abort and completion
      if (abort) begin
         flag_nxt = 1'b1;
         finish = 1'b1;
         {scl_rel_nxt, sda_rel_nxt, cs_nxt, sck_nxt, dout_nxt} = 5'b11000;
      end
      if (finish) begin
         state_nxt = nv_ctrl_pkg::ST_IDLE;
         to_nxt = '0;
         if (from_ldr_r) begin
            lvalid_nxt = !abort;
            lbyte_nxt = rbyte;
            lidx_nxt = idx_r;
            idx_nxt = idx_r + 16'h0001;
            if (abort || idx_r == L_LAST) begin
               ldr_nxt = 1'b0;
               if (reload_r) begin
                  busy_nxt = 1'b0;
                  reload_nxt = 1'b0;
               end
            end
         end else begin
            busy_nxt = 1'b0;
            if (rd && !abort) data_nxt = rbyte;
         end
      end
      // pin drive per link kind, all released until straps are caught
      pins_nxt = 8'h00;
      if (boot_done_nxt) begin
         if (type_nxt) pins_nxt = {1'b0, !sda_rel_nxt, 1'b0, 1'b0, !scl_rel_nxt, 1'b0, 1'b0, 1'b1};
         else pins_nxt = {1'b1, 1'b0, 1'b0, sck_nxt, 1'b1, cs_nxt, dout_nxt, 1'b1};
      end
   end

   // state registers
   always_ff @(posedge clk or negedge rstn_r) begin
      if (!rstn_r) begin
         state_r <= nv_ctrl_pkg::ST_IDLE;
         {boot_r, q_r, size_r, div_r, to_r, step_r} <= '0;
         {cur_cmd_r, op_cmd_r, bit_r, len_r, sh_r, rx_r} <= '0;
         {cur_loc_r, op_loc_r, idx_r, lidx_r, lbyte_r} <= '0;
         data_r <= nv_ctrl_pkg::DATA_RST;
         {type_r, boot_done_r, busy_r, flag_r, ldr_r, from_ldr_r, reload_r, lvalid_r, mw_wait_r} <= '0;
         {scl_rel_r, sda_rel_r, cs_r, sck_r, dout_r} <= 5'b11000;
         pins_r <= 8'h00;
      end else if (ce) begin
         state_r <= state_nxt;
         {boot_r, q_r, size_r, div_r, to_r, step_r} <= {boot_nxt, q_nxt, size_nxt, div_nxt, to_nxt, step_nxt};
         {cur_cmd_r, op_cmd_r, bit_r, len_r, sh_r, rx_r} <= {cur_cmd_nxt, op_cmd_nxt, bit_nxt, len_nxt, sh_nxt, rx_nxt};
         {cur_loc_r, op_loc_r, idx_r, lidx_r, lbyte_r} <= {cur_loc_nxt, op_loc_nxt, idx_nxt, lidx_nxt, lbyte_nxt};
         data_r <= data_nxt;
         {type_r, boot_done_r, busy_r, flag_r, ldr_r} <= {type_nxt, boot_done_nxt, busy_nxt, flag_nxt, ldr_nxt};
         {from_ldr_r, reload_r, lvalid_r, mw_wait_r} <= {from_ldr_nxt, reload_nxt, lvalid_nxt, mw_wait_nxt};
         {scl_rel_r, sda_rel_r, cs_r, sck_r, dout_r} <= {scl_rel_nxt, sda_rel_nxt, cs_nxt, sck_nxt, dout_nxt};
         pins_r <= pins_nxt;
      end
   end

   // outputs straight from flops
   assign op_in_progress_bit = busy_r;
   assign no_response_flag = flag_r;
   assign nv_data_reg = data_r;
   assign loader_active = ldr_r;
   assign load_valid = lvalid_r;
   assign load_index = lidx_r;
   assign load_byte = lbyte_r;
   assign {threewire_in_pulldown, twowire_data_pin_oe, twowire_data_pin_out, twowire_clock_pin_out} = pins_r[7:4];
   assign {twowire_clock_pin_oe, threewire_select_pin_out, threewire_out_pin_out, threewire_select_pin_oe} = pins_r[3:0];
   assign threewire_out_pin_oe = pins_r[0];
endmodule : nv_eeprom_ctrl

// ==== verif/nv_ctrl_props.sv ====
// assertion checker for the serial memory command controller
`timescale 1ns/1ps
module nv_ctrl_props #(
   parameter int TIMEOUT_CYC = 2000,
   parameter int LOAD_LEN = 2
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic cmd_write,
   input wire logic cmd_start,
   input wire logic cmd_flag_clear,
   input wire logic op_in_progress_bit,
   input wire logic no_response_flag,
   input wire logic loader_active,
   input wire logic load_valid,
   input wire logic threewire_in_pulldown,
   input wire logic twowire_data_pin_oe,
   input wire logic threewire_select_pin_oe,
   input wire logic threewire_select_pin_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [31:0] busy_cnt_r;
   logic [31:0] busy_cnt_nxt;
   // length of the current busy spell
   always_comb busy_cnt_nxt = op_in_progress_bit ? busy_cnt_r + 32'h1 : 32'h0;
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         busy_cnt_r <= 32'h0;
      else
         busy_cnt_r <= busy_cnt_nxt;
   // port relations
   busy_start_a: assert property (
      ce && cmd_write && cmd_start && !op_in_progress_bit && !loader_active && threewire_select_pin_oe
      |=> op_in_progress_bit) else $error("busy did not rise on start");
   loader_hold_a: assert property (
      loader_active && !op_in_progress_bit |=> !op_in_progress_bit) else $error("command taken during load");
   pins_three_a: assert property (
      threewire_in_pulldown && threewire_select_pin_oe |-> !twowire_data_pin_oe) else $error("data pin driven");
   pins_two_a: assert property (
      threewire_select_pin_oe && !threewire_in_pulldown |-> !threewire_select_pin_out) else $error("select high");
   load_pulse_a: assert property (
      load_valid |=> !load_valid [*8]) else $error("load pulse too long");
   busy_bound_a: assert property (
      busy_cnt_r <= 32'(TIMEOUT_CYC + LOAD_LEN * 12000 + 12000)) else $error("busy never released");
   flag_clear_a: assert property (
      ce && cmd_write && cmd_flag_clear && !op_in_progress_bit |=> !no_response_flag) else $error("flag kept");
   flag_hold_a: assert property (
      no_response_flag && !(ce && cmd_write && cmd_flag_clear) |=> no_response_flag) else $error("flag lost");
   cover property ($rose(op_in_progress_bit));
   cover property ($rose(no_response_flag));
   cover property (load_valid);
endmodule : nv_ctrl_props
bind nv_eeprom_ctrl nv_ctrl_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .LOAD_LEN(LOAD_LEN)) i_nv_ctrl_props (.clk, .resetn,
   .ce, .cmd_write, .cmd_start, .cmd_flag_clear, .op_in_progress_bit, .no_response_flag, .loader_active,
   .load_valid, .threewire_in_pulldown, .twowire_data_pin_oe, .threewire_select_pin_oe, .threewire_select_pin_out);

// ==== verif/nv_mem_model.sv ====
// three-wire serial memory answering every read with one fixed byte
`timescale 1ns/1ps
module nv_mem_model #(
   parameter logic [7:0] PAT = 8'ha6
) (
   input wire logic select,
   input wire logic sck,
   input wire logic mute,
   output logic data_out
);
   int fall_cnt = 0;
   // falling clock edges seen since select rose
   always @(negedge sck or negedge select)
      if (!select)
         fall_cnt <= 0;
      else
         fall_cnt <= fall_cnt + 1;
   // pulled low when deselected or muted; read byte msb first in last eight clocks; ready high otherwise
   always_comb
      if (!select || mute)
         data_out = 1'b0;
      else if (fall_cnt >= 10 && fall_cnt < 18)
         data_out = PAT[17 - fall_cnt];
      else
         data_out = 1'b1;
endmodule : nv_mem_model

// ==== verif/nv_eeprom_ctrl_tb_top.sv ====
// self-checking bench for the serial memory command controller
`timescale 1ns/1ps
module nv_eeprom_ctrl_tb_top;
   localparam int TOC = 2000;
   localparam logic [7:0] PAT = 8'ha6;
   logic clk, resetn, link_type_strap, cmd_write, cmd_start, cmd_flag_clear, data_write, mute, mem_do;
   logic [2:0] cmd_code;
   logic [15:0] cmd_location, load_index;
   logic [7:0] data_wdata, nv_data_reg, load_byte;
   logic op_in_progress_bit, no_response_flag, loader_active, load_valid, threewire_in_pulldown;
   logic twowire_data_pin_out, twowire_data_pin_oe, twowire_clock_pin_out, twowire_clock_pin_oe;
   logic threewire_select_pin_out, threewire_select_pin_oe, threewire_out_pin_out, threewire_out_pin_oe;
   wire logic twowire_data_pin_in = twowire_data_pin_oe ? twowire_data_pin_out : (link_type_strap | mem_do);
   wire logic twowire_clock_pin_in = twowire_clock_pin_oe ? twowire_clock_pin_out : 1'b1;
   int n_fail = 0;
   int n_compared = 0;
   nv_eeprom_ctrl #(.TIMEOUT_CYC(TOC), .LOAD_LEN(2)) i_nv_eeprom_ctrl (.clk, .resetn, .ce(1'b1), .link_type_strap,
      .size_range_strap(2'h0), .cmd_write, .cmd_code, .cmd_location, .cmd_start, .cmd_flag_clear, .data_write,
      .data_wdata, .op_in_progress_bit, .no_response_flag, .nv_data_reg, .loader_active, .load_valid, .load_index,
      .load_byte, .twowire_data_pin_in, .twowire_data_pin_out, .twowire_data_pin_oe, .threewire_in_pulldown,
      .twowire_clock_pin_in, .twowire_clock_pin_out, .twowire_clock_pin_oe, .threewire_select_pin_out,
      .threewire_select_pin_oe, .threewire_out_pin_out, .threewire_out_pin_oe);
   nv_mem_model #(.PAT(PAT)) i_nv_mem_model (.select(threewire_select_pin_out), .sck(twowire_clock_pin_out),
      .mute, .data_out(mem_do));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   // data register first, then command register
   task automatic cmd(input logic [2:0] code, input logic start, input logic clr);
      @(negedge clk);
      data_write = 1'b1;
      @(negedge clk);
      data_write = 1'b0;
      {cmd_code, cmd_start, cmd_flag_clear, cmd_write} = {code, start, clr, 1'b1};
      @(negedge clk);
      cmd_write = 1'b0;
   endtask : cmd
   task automatic run(input logic [2:0] code, input int lim);
      cmd(code, 1'b1, 1'b0);
      check(op_in_progress_bit, 1);
      for (int i = 0; i < lim && op_in_progress_bit !== 1'b0; i++) @(negedge clk);
      check(op_in_progress_bit, 0);
   endtask : run
   task automatic do_reset(input logic two);
      link_type_strap = two;
      resetn = 1'b0;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      for (int i = 0; i < 20 && loader_active !== 1'b1; i++) @(negedge clk);
   endtask : do_reset
   task automatic t_loader;
      int n = 0;
      check({threewire_in_pulldown, twowire_data_pin_oe, threewire_select_pin_oe}, 3'b101);
      cmd(nv_ctrl_pkg::CMD_READ, 1'b1, 1'b0);
      check(op_in_progress_bit, 0);
      // last pulse comes with the loader's release
      for (int i = 0; i < 20000 && (loader_active === 1'b1 || load_valid === 1'b1); i++) begin
         if (load_valid === 1'b1) begin
            check(load_index, n);
            check(load_byte, PAT);
            n++;
         end
         @(negedge clk);
      end
      check(n, 2);
   endtask : t_loader
   task automatic t_commands;
      run(nv_ctrl_pkg::CMD_READ, 8000);
      check(nv_data_reg, PAT);
      // protect off comes before every erase and write
      for (int c = 1; c < 8; c++) begin
         run(3'(c), 12000);
         check(no_response_flag, 0);
      end
   endtask : t_commands
   task automatic t_timeout;
      mute = 1'b1;
      run(nv_ctrl_pkg::CMD_ERASE, TOC + 8000);
      check(no_response_flag, 1);
      mute = 1'b0;
      cmd(nv_ctrl_pkg::CMD_READ, 1'b0, 1'b1);
      check(no_response_flag, 0);
   endtask : t_timeout
   task automatic t_twowire;
      do_reset(1'b1);
      for (int i = 0; i < 20000 && loader_active === 1'b1; i++) @(negedge clk);
      check({no_response_flag, threewire_in_pulldown, threewire_select_pin_out, threewire_out_pin_out}, 4'h8);
      cmd(nv_ctrl_pkg::CMD_READ, 1'b0, 1'b1);
      run(nv_ctrl_pkg::CMD_ERASE_EVERY, 3);
      check(no_response_flag, 0);
      run(nv_ctrl_pkg::CMD_READ, 20000);
      check(no_response_flag, 1);
   endtask : t_twowire
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      {resetn, link_type_strap, cmd_write, cmd_start, cmd_flag_clear, data_write, mute} = 7'h0;
      cmd_code = 3'h0;
      cmd_location = 16'h0005;
      data_wdata = 8'h3c;
      do_reset(1'b0);
      t_loader;
      t_commands;
      t_timeout;
      t_twowire;
      tally_and_finish;
   end
   // watchdog at twice the expected run of about 45k cycles
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      tally_and_finish;
   end
endmodule : nv_eeprom_ctrl_tb_top
